// [hdl/mu_params.svh]
`ifndef MU_PARAMS_SVH
`define MU_PARAMS_SVH

// ==========================================================
// stack geometry
`define MU_STACK_BYTES 16
`define MU_PTR_W       4

// ==========================================================
// error codes of the status byte
`define MU_ERR_NONE    4'h0
`define MU_ERR_DIV0    4'h8
`define MU_ERR_NEGARG  4'h4
`define MU_ERR_ARGBIG  4'hC
`define MU_ERR_UNDER   4'h2
`define MU_ERR_OVER    4'h1

// ==========================================================
// floating point exponent range
`define MU_EXP_MIN     (-64)
`define MU_EXP_MAX     63

// ==========================================================
// command codes handled by the datapath, bit 7 ignored
`define MU_OP_ADD16    7'h6C
`define MU_OP_SUB16    7'h6D
`define MU_OP_ADD32    7'h2C
`define MU_OP_SUB32    7'h2D
`define MU_OP_CHSF     7'h15
`define MU_FMT_FIX16   2'h3
`define MU_FMT_FIX32   2'h1

// ==========================================================
// timing and buffering
`define MU_EXEC_CYCLES 16
`define MU_BUF_DEPTH   2

`endif

// [hdl/mu_pkg.sv]
package mu_pkg;

  // ==========================================================
  // host pins, all active low except the select and data
  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic       portSel;
    logic       resetSelN;
    logic [7:0] data;
  } mu_host_t;

  // ==========================================================
  // operand and status layouts
  typedef struct packed {
    logic        sign;
    logic [6:0]  exp;
    logic [23:0] mant;
  } mu_float_t;

  typedef struct packed {
    logic       busy;
    logic       sign;
    logic       zero;
    logic [3:0] err;
    logic       carry;
  } mu_status_t;

  typedef enum logic [1:0] {
    MU_IDLE  = 2'b00,
    MU_EXEC  = 2'b01,
    MU_WBACK = 2'b11
  } mu_state_t;

  typedef enum logic [1:0] {
    MU_FIX16 = 2'b00,
    MU_FIX32 = 2'b01,
    MU_FLOAT = 2'b10
  } mu_fmt_t;

endpackage

// [hdl/mu_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module mu_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  import mu_pkg::*;

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] memQ [DEPTH];
  logic [WIDTH-1:0] memD [DEPTH];
  logic [AW-1:0]    wrQ, wrD, rdQ, rdD;
  logic [AW:0]      cntQ, cntD;
  logic             push, pop;

  assign inReady  = cntQ != FULL;
  assign outValid = cntQ != '0;
  assign outData  = memQ[rdQ];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    memD = memQ;
    wrD  = wrQ;
    rdD  = rdQ;
    cntD = cntQ;
    if (push) begin
      memD[wrQ] = inData;
      wrD       = (wrQ == LAST) ? '0 : AW'(wrQ + 1'b1);
    end
    if (pop) begin
      rdD = (rdQ == LAST) ? '0 : AW'(rdQ + 1'b1);
    end
    cntD = (AW+1)'(cntQ + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clk) begin
    memQ <= memD;
    if (!rst_n) begin
      wrQ  <= '0;
      rdQ  <= '0;
      cntQ <= '0;
    end else begin
      wrQ  <= wrD;
      rdQ  <= rdD;
      cntQ <= cntD;
    end
  end

  // ==========================================================
  // checks
  AST_FIFO_STALL_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
    outValid && !outReady |=> outValid && $stable(outData))
    else $error("buffered byte changed while stalled");
  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    push && !pop |=> cntQ == (AW+1)'($past(cntQ) + 1'b1) && cntQ <= FULL)
    else $error("buffer count out of range");

endmodule

`default_nettype wire

// [hdl/mu_math_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mu_params.svh"

module mu_math_unit #(
  parameter int unsigned EXEC_CYCLES = `MU_EXEC_CYCLES,
  parameter int unsigned BUF_DEPTH   = `MU_BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire mu_pkg::mu_host_t hostIn,
  input  wire logic             doneAcknowledgeN,
  output logic            [7:0] rdData,
  output logic                  rdDataOe,
  output logic                  doneIrq,
  output logic                  holdRequestN
);
  import mu_pkg::*;

  localparam logic [7:0] EXEC_LAST = 8'(EXEC_CYCLES - 1);

  // ==========================================================
  // state
  // sixteen-byte stack
  logic [7:0]          stackQ [`MU_STACK_BYTES];
  logic [7:0]          stackD [`MU_STACK_BYTES];
  logic [`MU_PTR_W-1:0] ptrQ, ptrD;
  mu_state_t           stateQ, stateD;
  mu_fmt_t             fmtQ, fmtD;
  logic [7:0]          cntQ, cntD;
  logic [7:0]          cmdQ, cmdD;
  logic [3:0]          errQ, errD;
  logic                carryQ, carryD;
  logic                irqQ, irqD;
  logic [7:0]          rdDataQ, rdDataD;
  logic                oeQ, oeD;
  logic                holdQ, holdD;
  logic                accDoneQ, accDoneD;

  // ==========================================================
  // host decode
  logic cs, rdA, wrA, dataWr, dataRd, cmdWr, statRd, resetPort;
  logic busy, idleEmpty, anyStrobe, allowed, accept;
  logic bufInReady, bufOutValid, bufOutReady, drain;
  logic [7:0] bufOut;

  assign cs        = !hostIn.csN;
  assign rdA       = cs && !hostIn.rdN;
  assign wrA       = cs && !hostIn.wrN;
  assign dataWr    = wrA && !hostIn.portSel;
  assign dataRd    = rdA && !hostIn.portSel;
  assign cmdWr     = wrA && hostIn.portSel;
  assign statRd    = rdA && hostIn.portSel;
  assign resetPort = !hostIn.resetSelN && !hostIn.wrN;
  assign busy      = stateQ != MU_IDLE;
  assign idleEmpty = !busy && !bufOutValid;
  assign anyStrobe = dataWr || dataRd || cmdWr || statRd;
  // pushes may queue while busy; pops and commands wait for an idle, drained stack
  // status never stalls
  assign allowed   = statRd || (dataWr && bufInReady) || ((dataRd || cmdWr) && idleEmpty);
  // one action per strobe, however long the host holds it
  assign accept    = anyStrobe && allowed && !accDoneQ && !resetPort;
  // stack is owned by the datapath while a command runs
  assign bufOutReady = !busy && !resetPort;
  assign drain       = bufOutValid && bufOutReady;

  mu_fifo #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_pushBuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (accept && dataWr),
    .inData   (hostIn.data),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outData  (bufOut),
    .outReady (bufOutReady)
  );

  // ==========================================================
  // operand views
  function automatic logic [`MU_PTR_W-1:0] idx(input logic [`MU_PTR_W-1:0] k);
    idx = `MU_PTR_W'(ptrQ - k);
  endfunction

  logic [31:0] top32, nos32;
  logic [15:0] top16, nos16;
  logic [32:0] sum33;
  logic [16:0] sum17;
  logic        subOp, ovf16, ovf32;
  mu_float_t   fl;
  mu_status_t  status;

  assign top32 = {stackQ[idx(4'h1)], stackQ[idx(4'h2)], stackQ[idx(4'h3)], stackQ[idx(4'h4)]};
  assign nos32 = {stackQ[idx(4'h5)], stackQ[idx(4'h6)], stackQ[idx(4'h7)], stackQ[idx(4'h8)]};
  assign top16 = top32[31:16];
  assign nos16 = top32[15:0];
  assign subOp = cmdQ[0];
  assign sum33 = subOp ? {1'b0, nos32} - {1'b0, top32} : {1'b0, nos32} + {1'b0, top32};
  assign sum17 = subOp ? {1'b0, nos16} - {1'b0, top16} : {1'b0, nos16} + {1'b0, top16};
  assign ovf16 = ((nos16[15] ^ top16[15]) == subOp) && (sum17[15] != nos16[15]);
  assign ovf32 = ((nos32[31] ^ top32[31]) == subOp) && (sum33[31] != nos32[31]);
  assign fl    = mu_float_t'(top32);

  always_comb begin
    status.busy  = busy;
    status.sign  = fl.sign;
    unique case (fmtQ)
      MU_FIX16: status.zero = top16 == '0;
      MU_FIX32: status.zero = top32 == '0;
      default:  status.zero = fl.mant == '0;
    endcase
    status.err   = errQ;
    status.carry = carryQ;
  end

  // ==========================================================
  // next state
  always_comb begin
    stackD   = stackQ;
    ptrD     = ptrQ;
    stateD   = stateQ;
    fmtD     = fmtQ;
    cntD     = cntQ;
    cmdD     = cmdQ;
    errD     = errQ;
    carryD   = carryQ;
    irqD     = irqQ;
    rdDataD  = rdDataQ;
    accDoneD = anyStrobe && (accDoneQ || accept);
    oeD      = rdA;
    // stall only an access that cannot proceed
    holdD    = !(anyStrobe && !allowed && !accDoneQ && !resetPort);
    if (!doneAcknowledgeN) irqD = 1'b0;
    if (accept) irqD = 1'b0;
    if (accept && statRd) rdDataD = status;
    if (accept && dataRd) begin
      rdDataD = stackQ[idx(4'h1)];
      ptrD    = idx(4'h1);
    end
    if (drain) begin
      stackD[ptrQ] = bufOut;
      ptrD         = `MU_PTR_W'(ptrQ + 1'b1);
    end
    unique case (stateQ)
      MU_IDLE: begin
        if (accept && cmdWr) begin
          cmdD   = hostIn.data;
          cntD   = '0;
          stateD = MU_EXEC;
          unique case (hostIn.data[6:5])
            `MU_FMT_FIX16: fmtD = MU_FIX16;
            `MU_FMT_FIX32: fmtD = MU_FIX32;
            default:       fmtD = MU_FLOAT;
          endcase
        end
      end
      MU_EXEC: begin
        if (cntQ >= EXEC_LAST) begin
          stateD = MU_WBACK;
        end else begin
          cntD = 8'(cntQ + 1'b1);
        end
      end
      MU_WBACK: begin
        stateD = MU_IDLE;
        errD   = `MU_ERR_NONE;
        carryD = 1'b0;
        unique case (cmdQ[6:0])
          `MU_OP_ADD16, `MU_OP_SUB16: begin
            {stackD[idx(4'h3)], stackD[idx(4'h4)]} = sum17[15:0];
            ptrD   = idx(4'h2);
            carryD = sum17[16];
            errD   = ovf16 ? `MU_ERR_OVER : `MU_ERR_NONE;
          end
          `MU_OP_ADD32, `MU_OP_SUB32: begin
            {stackD[idx(4'h5)], stackD[idx(4'h6)],
             stackD[idx(4'h7)], stackD[idx(4'h8)]} = sum33[31:0];
            ptrD   = idx(4'h4);
            carryD = sum33[32];
            errD   = ovf32 ? `MU_ERR_OVER : `MU_ERR_NONE;
          end
          `MU_OP_CHSF: stackD[idx(4'h1)] = {~fl.sign, stackQ[idx(4'h1)][6:0]};
          default: ;
        endcase
        irqD = 1'b1;
      end
      default: stateD = MU_IDLE;
    endcase
    if (resetPort) begin
      stateD = MU_IDLE;
      cntD   = '0;
      errD   = `MU_ERR_NONE;
      carryD = 1'b0;
      irqD   = 1'b0;
    end
  end

  // ==========================================================
  // registers; stack data deliberately survives reset
  always_ff @(posedge clk) begin
    stackQ <= stackD;
    if (!rst_n) begin
      ptrQ     <= '0;
      stateQ   <= MU_IDLE;
      fmtQ     <= MU_FLOAT;
      cntQ     <= '0;
      cmdQ     <= '0;
      errQ     <= `MU_ERR_NONE;
      carryQ   <= 1'b0;
      irqQ     <= 1'b0;
      rdDataQ  <= '0;
      oeQ      <= 1'b0;
      holdQ    <= 1'b1;
      accDoneQ <= 1'b0;
    end else begin
      ptrQ     <= ptrD;
      stateQ   <= stateD;
      fmtQ     <= fmtD;
      cntQ     <= cntD;
      cmdQ     <= cmdD;
      errQ     <= errD;
      carryQ   <= carryD;
      irqQ     <= irqD;
      rdDataQ  <= rdDataD;
      oeQ      <= oeD;
      holdQ    <= holdD;
      accDoneQ <= accDoneD;
    end
  end

  assign rdData       = rdDataQ;
  assign rdDataOe     = oeQ;
  assign doneIrq      = irqQ;
  assign holdRequestN = holdQ;

  // ==========================================================
  // checks
  AST_DONE_RISES: assert property (@(posedge clk) disable iff (!rst_n)
    stateQ == MU_WBACK && !resetPort |=> doneIrq && !busy)
    else $error("done not raised at completion");
  AST_DONE_ACK: assert property (@(posedge clk) disable iff (!rst_n)
    !doneAcknowledgeN && stateQ != MU_WBACK |=> !doneIrq)
    else $error("acknowledge did not clear done");
  AST_DONE_ACCESS: assert property (@(posedge clk) disable iff (!rst_n)
    accept && stateQ != MU_WBACK |=> !doneIrq)
    else $error("host access did not clear done");
  AST_HOLD_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    !holdRequestN |-> $past(busy || bufOutValid))
    else $error("hold asserted while able to communicate");
  AST_STATUS_ANYTIME: assert property (@(posedge clk) disable iff (!rst_n)
    accept && statRd |=> rdData[7] == $past(busy) && rdData[4:1] == $past(errQ))
    else $error("status byte wrong");
  AST_PUSH_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    drain |=> ptrQ == 4'($past(ptrQ) + 4'h1) && stackQ[$past(ptrQ)] == $past(bufOut))
    else $error("push did not advance pointer");
  AST_POP_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    accept && dataRd |=> rdData == $past(stackQ[idx(4'h1)]) && ptrQ == 4'($past(ptrQ) - 4'h1))
    else $error("pop returned wrong byte");
  AST_RESET_PORT: assert property (@(posedge clk) disable iff (!rst_n)
    resetPort |=> stateQ == MU_IDLE && errQ == 4'h0 && !carryQ && !doneIrq)
    else $error("reset port did not abort");
  AST_EXEC_ALONE: assert property (@(posedge clk) disable iff (!rst_n)
    stateQ == MU_IDLE && accept && cmdWr ##1 !resetPort |-> busy[*2])
    else $error("command did not start");
  AST_ADD16_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
    stateQ == MU_WBACK && cmdQ[6:0] == 7'h6C && !resetPort
    |=> {stackQ[idx(4'h1)], stackQ[idx(4'h2)]} == 16'($past(nos16) + $past(top16)))
    else $error("sum not on top");

endmodule

`default_nettype wire

// [tb/mu_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side: programmed byte transfers on the unit's port
module mu_host_model (
  input  wire logic             clk,
  input  wire logic             holdRequestN,
  output var  mu_pkg::mu_host_t hostOut
);
  import mu_pkg::*;
  logic sawHold;
  logic timedOut;

  initial begin
    hostOut = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h5A};
    sawHold = 1'b0;
    timedOut = 1'b0;
  end

  // ==========================================================
  // one strobe, held until the unit stops asking to wait
  // portSel with one strobe picks the transfer
  task automatic xfer(input logic sel, input logic rd, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    sawHold = 1'b0;
    hostOut.portSel = sel;
    hostOut.data = b;
    hostOut.rdN = ~rd;
    hostOut.wrN = rd;
    hostOut.csN = 1'b0;
    do begin
      @(posedge clk);
      @(negedge clk);
      if (holdRequestN !== 1'b1) sawHold = 1'b1;
      n++;
    end while (holdRequestN !== 1'b1 && n < 300);
    if (n >= 300) timedOut = 1'b1;
    hostOut.csN = 1'b1;
    hostOut.rdN = 1'b1;
    hostOut.wrN = 1'b1;
    // released bus shows the inverse so a stale byte cannot pass
    hostOut.data = ~b;
  endtask

  task automatic pushOp(input int nb, input logic [31:0] v);
    for (int i = 0; i < nb; i++) begin
      xfer(1'b0, 1'b0, v[8*i +: 8]);
    end
  endtask

  // reset select with write strobe, chip select left high
  task automatic resetPort();
    @(negedge clk);
    hostOut.resetSelN = 1'b0;
    hostOut.wrN = 1'b0;
    @(negedge clk);
    hostOut.resetSelN = 1'b1;
    hostOut.wrN = 1'b1;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mu_pkg::*;
  localparam int unsigned EXEC = 40;
  typedef struct packed {
    logic [7:0] v;
    logic [7:0] m;
  } mu_exp_t;
  logic        clk;
  logic        rst_n;
  logic        ackN;
  mu_host_t    hostIn;
  logic [7:0]  rdData;
  logic        rdDataOe;
  logic        doneIrq;
  logic        holdRequestN;
  mu_exp_t     expQ[$];
  mu_exp_t     e;
  logic [7:0]  b[18];
  logic [7:0]  ops[6] = '{8'h6C, 8'h6D, 8'h2C, 8'h2D, 8'hEC, 8'hAD};
  logic [31:0] f;
  logic [31:0] x;
  logic [31:0] y;
  int          n_fail;
  int          n_checks;

  mu_math_unit #(.EXEC_CYCLES(EXEC), .BUF_DEPTH(2)) mu_math_unit_inst (
    .clk(clk), .rst_n(rst_n), .hostIn(hostIn), .doneAcknowledgeN(ackN),
    .rdData(rdData), .rdDataOe(rdDataOe), .doneIrq(doneIrq), .holdRequestN(holdRequestN));
  mu_host_model mu_host_model_inst (.clk(clk), .holdRequestN(holdRequestN), .hostOut(hostIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // report and compare
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // read bytes are judged when the output enable drops, the byte stands till then
  initial forever begin
    @(negedge rdDataOe);
    if (rst_n === 1'b1) begin
      if (expQ.size() == 0) begin
        n_fail++;
        $display("[FAIL] %0t got %h expected none", $time, rdData);
      end else begin
        e = expQ.pop_front();
        check(rdData, e.v, e.m);
      end
    end
  end

  initial begin
    wait (mu_host_model_inst.timedOut === 1'b1);
    n_fail++;
    summarize();
  end

  // ==========================================================
  // host operations
  task automatic note(input logic [7:0] v, input logic [7:0] m);
    expQ.push_back('{v, m});
  endtask

  task automatic pop(input int nb, input logic [31:0] v);
    for (int i = nb - 1; i >= 0; i--) begin
      note(v[8*i +: 8], 8'hFF);
      mu_host_model_inst.xfer(1'b0, 1'b1, 8'h00);
    end
  endtask

  task automatic status(input logic [7:0] v, input logic [7:0] m);
    note(v, m);
    mu_host_model_inst.xfer(1'b1, 1'b1, 8'h00);
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    while (doneIrq !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic aluCase(input logic [7:0] op, input logic [31:0] xi, input logic [31:0] yi,
                         input logic useAck);
    int w;
    logic [32:0] r;
    logic [31:0] m;
    logic [31:0] res;
    logic ov;
    w = op[6] ? 16 : 32;
    m = op[6] ? 32'h0000FFFF : 32'hFFFFFFFF;
    r = op[0] ? {1'b0, xi & m} - {1'b0, yi & m} : {1'b0, xi & m} + {1'b0, yi & m};
    res = r[31:0] & m;
    ov = (xi[w-1] ^ yi[w-1] ^ ~op[0]) & (res[w-1] ^ xi[w-1]);
    mu_host_model_inst.pushOp(w / 8, xi & m);
    mu_host_model_inst.pushOp(w / 8, yi & m);
    mu_host_model_inst.xfer(1'b1, 1'b0, op);
    // only busy is meaningful while the command runs
    status(8'h80, 8'h80);
    waitDone();
    if (useAck) begin
      @(negedge clk);
      ackN = 1'b0;
      @(negedge clk);
      ackN = 1'b1;
      check({7'h00, doneIrq}, 8'h00, 8'hFF);
    end
    status({1'b0, res[w-1], res == 32'h0, ov ? 4'h1 : 4'h0, r[w]}, 8'hFF);
    check({7'h00, doneIrq}, 8'h00, 8'hFF);
    pop(w / 8, res);
    $display("test alu %h done", op);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    ackN = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    void'($urandom(12));
    for (int i = 0; i < 18; i++) begin
      b[i] = 8'($urandom);
      mu_host_model_inst.xfer(1'b0, 1'b0, b[i]);
    end
    for (int k = 0; k < 2; k++) begin
      for (int i = 17; i >= 2; i--) begin
        note(b[i], 8'hFF);
        mu_host_model_inst.xfer(1'b0, 1'b1, 8'h00);
      end
    end
    $display("test stack done");
    aluCase(8'h6C, 32'h0005, 32'hFFFB, 1'b1);
    aluCase(8'h6C, 32'h7FFF, 32'h0001, 1'b0);
    for (int k = 0; k < 12; k++) begin
      aluCase(ops[k % 6], $urandom, $urandom, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      f = {1'($urandom), 7'($urandom), 1'b1, 23'($urandom)};
      mu_host_model_inst.pushOp(4, f);
      mu_host_model_inst.xfer(1'b1, 1'b0, j ? 8'h95 : 8'h15);
      waitDone();
      status({1'b0, ~f[31], 6'h00}, 8'hFE);
      pop(4, {~f[31], f[30:0]});
    end
    $display("test float done");
    x = 32'($urandom) & 32'hFFFF;
    y = 32'($urandom) & 32'hFFFF;
    mu_host_model_inst.pushOp(2, x);
    mu_host_model_inst.pushOp(2, y);
    mu_host_model_inst.xfer(1'b1, 1'b0, 8'h6C);
    for (int i = 0; i < 3; i++) begin
      b[i] = 8'($urandom);
      mu_host_model_inst.xfer(1'b0, 1'b0, b[i]);
      check({7'h00, mu_host_model_inst.sawHold}, {7'h00, i == 2}, 8'hFF);
    end
    check({7'h00, doneIrq}, 8'h00, 8'hFF);
    for (int i = 2; i >= 0; i--) begin
      note(b[i], 8'hFF);
      mu_host_model_inst.xfer(1'b0, 1'b1, 8'h00);
    end
    pop(2, (x + y) & 32'hFFFF);
    $display("test buffer done");
    mu_host_model_inst.pushOp(2, x);
    mu_host_model_inst.pushOp(2, y);
    mu_host_model_inst.xfer(1'b1, 1'b0, 8'h6D);
    mu_host_model_inst.resetPort();
    status(8'h00, 8'h9F);
    repeat (EXEC + 5) @(negedge clk);
    check({7'h00, doneIrq}, 8'h00, 8'hFF);
    pop(2, y);
    $display("test reset port done");
    aluCase(8'h6C, 32'h8000, 32'h8000, 1'b0);
    mu_host_model_inst.xfer(1'b1, 1'b0, 8'h00);
    waitDone();
    status(8'h00, 8'h9F);
    $display("test other command done");
    repeat (5) @(negedge clk);
    check(8'(expQ.size()), 8'h00, 8'hFF);
    summarize();
  end
endmodule
`default_nettype wire
